// File: rtl/trace_capture_pkg.sv
// Package: constants, register map and carrier types for the trace capture block
`default_nettype none
package trace_capture_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int NUM_RANGES = 2;
	localparam int NUM_POINTS = 2;
	localparam int BUF_AW = 4;
	localparam int BUF_DEPTH = 16;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFF_RD_PTR = 8'h10;
	localparam logic [7:0] OFF_RD_DATA = 8'h14;
	localparam logic [7:0] OFF_WR_PTR = 8'h18;
	localparam logic [7:0] OFF_RANGE_BASE = 8'h20;
	localparam logic [7:0] OFF_POINT_BASE = 8'h40;

	// Control register fields
	localparam int CTRL_RANGE_EN = 0;
	localparam int CTRL_START_EN = 4;
	localparam int CTRL_STOP_EN = 8;
	localparam int CTRL_TRIG_EN = 12;
	localparam int CTRL_STOP_ON_TRIG = 16;
	localparam int CTRL_FILL = 17;
	localparam int CTRL_RESTART = 31;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Post-trigger fill settings
	localparam logic [1:0] FILL_0 = 2'h0;
	localparam logic [1:0] FILL_50 = 2'h1;
	localparam logic [1:0] FILL_99 = 2'h2;
	localparam int FILL_50_PCT = 50;
	localparam int FILL_99_PCT = 99;

	// Interrupt status bits
	localparam int IRQ_TRIG = 0;
	localparam int IRQ_STOPPED = 1;
	localparam int IRQ_WRAP = 2;

	// Record tag in the top bit of each stored word
	localparam logic [DATA_W:0] TRIG_RECORD = {1'b1, 32'h7219_0000};

	// Incoming trace beat
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} trace_beat_t;

	// AHB-Lite slave request
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
	} ahb_req_t;

	typedef enum logic [1:0] {
		CAP_RUN,
		CAP_POST,
		CAP_DONE
	} cap_state_t;

endpackage
`default_nettype wire

// File: rtl/range_compare.sv
// Leaf: one address range comparator with inclusive bounds
`timescale 1ns/1ps
`default_nettype none
module range_compare (
	// Programmed range
	input wire logic [31:0] lo_in,
	input wire logic [31:0] hi_in,
	input wire logic enable_in,
	// Address under test
	input wire logic [31:0] addr_in,
	// Result
	output logic hit_out
);
	// Disabled comparators never hit
	assign hit_out = enable_in && (addr_in >= lo_in) && (addr_in <= hi_in);
endmodule
`default_nettype wire

// File: rtl/trace_capture.sv
// Trace capture: range filter, start/stop points, trigger, circular buffer
// Functional notes
// - Buffer wraps, overwriting oldest, until stopped
// - No range enabled: every address passes
// - Ranges enabled: capture only inside one
// - Ranges have start/end; calls need target inside
// - Range comparator count is a parameter
// - Point count parameter; never stalls processor
// - Start point address turns capture on
// - Stop point address turns capture off; the code does so only while a start point is enabled
// - Single on/off state, no nesting count
// - No start enabled: on; else off
// - First trigger hit inserts one record
// - Stop-on-trigger stops capture, not processor
// - Fill zero: stop right after trigger
// - Fill half: stop after half buffer
// - Fill 99 percent: stop after that
// - Source only observes, never alters processor
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module trace_capture (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Trace source, same clock domain
	input wire trace_capture_pkg::trace_beat_t beat_in,
	input wire logic ext_trigger_in,
	// AHB-Lite slave
	input wire trace_capture_pkg::ahb_req_t ahb_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Status
	output logic capturing_out,
	output logic irq_out
);
	import trace_capture_pkg::*;

	localparam int NR = NUM_RANGES;
	localparam int NP = NUM_POINTS;
	localparam int POST_50 = (BUF_DEPTH * FILL_50_PCT) / 100;
	localparam int POST_99 = (BUF_DEPTH * FILL_99_PCT) / 100;

	logic [31:0] ctrl_q;
	logic [31:0] range_lo_q [NR];
	logic [31:0] range_hi_q [NR];
	logic [31:0] point_addr_q [NP];
	logic [2:0] irq_stat_q;
	logic [2:0] irq_mask_q;
	logic [BUF_AW-1:0] rd_ptr_q;
	logic [BUF_AW-1:0] wr_ptr_q;
	logic [DATA_W:0] buf_q [BUF_DEPTH];
	logic [31:0] hrdata_q;
	logic on_q;
	logic trig_seen_q;
	logic pend_rec_q;
	logic [BUF_AW:0] post_cnt_q;
	cap_state_t state_q;

	// AHB data phase bookkeeping
	logic dp_wr_q;
	logic dp_rd_q;
	logic [7:0] dp_addr_q;
	logic wr_any;
	logic rd_any;
	logic restart;

	// Word offset match, reused by write and read decoders
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	// Zero-wait slave, always OKAY
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign hrdata_out = hrdata_q;

	assign wr_any = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1] && ahb_in.hwrite;
	assign rd_any = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1] && !ahb_in.hwrite;

	// Capture address phase
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else begin
			dp_wr_q <= wr_any;
			dp_rd_q <= rd_any;
			if (wr_any || rd_any) begin
				dp_addr_q <= ahb_in.haddr[7:0];
			end
		end
	end

	// Control register; restart bit self-clears
	assign restart = dp_wr_q && hit(dp_addr_q, OFF_CTRL) && hwdata_in[CTRL_RESTART];
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_q <= CTRL_RESET;
			irq_mask_q <= 3'h0;
			rd_ptr_q <= '0;
		end else begin
			if (dp_wr_q && hit(dp_addr_q, OFF_CTRL)) begin
				ctrl_q <= {1'b0, hwdata_in[30:0]};
			end
			if (dp_wr_q && hit(dp_addr_q, OFF_IRQ_MASK)) begin
				irq_mask_q <= hwdata_in[2:0];
			end
			if (dp_wr_q && hit(dp_addr_q, OFF_RD_PTR)) begin
				rd_ptr_q <= hwdata_in[BUF_AW-1:0];
			end else if (dp_rd_q && hit(dp_addr_q, OFF_RD_DATA)) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	// Range and point comparator registers
	genvar g;
	generate
		for (g = 0; g < NR; g++) begin : g_rreg
			always_ff @(posedge clock_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					range_lo_q[g] <= 32'h0000_0000;
					range_hi_q[g] <= 32'h0000_0000;
				end else if (dp_wr_q) begin
					if (hit(dp_addr_q, OFF_RANGE_BASE + 8'(8 * g))) begin
						range_lo_q[g] <= hwdata_in;
					end
					if (hit(dp_addr_q, OFF_RANGE_BASE + 8'(8 * g + 4))) begin
						range_hi_q[g] <= hwdata_in;
					end
				end
			end
		end
		for (g = 0; g < NP; g++) begin : g_preg
			always_ff @(posedge clock_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					point_addr_q[g] <= 32'h0000_0000;
				end else if (dp_wr_q && hit(dp_addr_q, OFF_POINT_BASE + 8'(4 * g))) begin
					point_addr_q[g] <= hwdata_in;
				end
			end
		end
	endgenerate

	// Range filter: each comparator is a range_compare instance
	logic [NR-1:0] range_hit;
	logic [NR-1:0] range_en;
	logic range_pass;
	generate
		for (g = 0; g < NR; g++) begin : g_rng
			assign range_en[g] = ctrl_q[CTRL_RANGE_EN + g];
			range_compare u_cmp (
				.lo_in(range_lo_q[g]),
				.hi_in(range_hi_q[g]),
				.enable_in(range_en[g]),
				.addr_in(beat_in.addr),
				.hit_out(range_hit[g])
			);
		end
	endgenerate
	// The executed address decides; a call target outside all ranges is dropped
	assign range_pass = (range_en == '0) ? 1'b1 : (|range_hit);

	// Start, stop and trigger point matches against one address each
	logic [NP-1:0] start_hit;
	logic [NP-1:0] stop_hit;
	logic [NP-1:0] trig_hit;
	logic [NP-1:0] start_en;
	generate
		for (g = 0; g < NP; g++) begin : g_pt
			logic match;
			assign start_en[g] = ctrl_q[CTRL_START_EN + g];
			assign match = beat_in.valid && (beat_in.addr == point_addr_q[g]);
			assign start_hit[g] = match && start_en[g];
			assign stop_hit[g] = match && ctrl_q[CTRL_STOP_EN + g];
			assign trig_hit[g] = match && ctrl_q[CTRL_TRIG_EN + g];
		end
	endgenerate

	// On/off state, no nesting; stop wins on a tie so a stop is never missed
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			on_q <= 1'b0;
		end else if (restart || (dp_wr_q && hit(dp_addr_q, OFF_CTRL))) begin
			on_q <= 1'b0;
		end else if (|stop_hit) begin
			on_q <= 1'b0;
		end else if (|start_hit) begin
			on_q <= 1'b1;
		end
	end
	logic ss_pass;
	assign ss_pass = (start_en == '0) || on_q || (|start_hit);

	// Trigger: the platform's line or a programmed point
	logic trig_now;
	logic first_trig;
	assign trig_now = ext_trigger_in || (|trig_hit);
	assign first_trig = trig_now && !trig_seen_q && (state_q == CAP_RUN);

	// Write qualifier; the source is never back-pressured
	logic write_ok;
	logic wr_en;
	logic [DATA_W:0] wr_word;
	assign write_ok = range_pass && ss_pass && (state_q != CAP_DONE);
	// Trigger record takes the slot first; the beat of that cycle is dropped
	assign wr_en = pend_rec_q ? (state_q != CAP_DONE) : (beat_in.valid && write_ok);
	assign wr_word = pend_rec_q ? TRIG_RECORD : {1'b0, beat_in.data};

	// Post-trigger target in buffer writes
	logic [BUF_AW:0] post_target;
	always_comb begin
		case (ctrl_q[CTRL_FILL +: 2])
			FILL_50: post_target = (BUF_AW+1)'(POST_50);
			FILL_99: post_target = (BUF_AW+1)'(POST_99);
			default: post_target = '0;
		endcase
	end

	// Capture state machine
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= CAP_RUN;
			trig_seen_q <= 1'b0;
			pend_rec_q <= 1'b0;
			post_cnt_q <= '0;
		end else if (restart) begin
			state_q <= CAP_RUN;
			trig_seen_q <= 1'b0;
			pend_rec_q <= 1'b0;
			post_cnt_q <= '0;
		end else begin
			if (first_trig) begin
				trig_seen_q <= 1'b1;
				pend_rec_q <= 1'b1;
			end else if (pend_rec_q) begin
				pend_rec_q <= 1'b0;
			end
			case (state_q)
				CAP_RUN: begin
					if (pend_rec_q && ctrl_q[CTRL_STOP_ON_TRIG]) begin
						post_cnt_q <= '0;
						state_q <= (post_target == '0) ? CAP_DONE : CAP_POST;
					end
				end
				CAP_POST: begin
					if (wr_en) begin
						post_cnt_q <= post_cnt_q + 1'b1;
						if (post_cnt_q + 1'b1 >= post_target) begin
							state_q <= CAP_DONE;
						end
					end
				end
				CAP_DONE: state_q <= CAP_DONE;
				default: state_q <= CAP_RUN;
			endcase
		end
	end

	// Circular buffer, oldest entry overwritten
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_q <= '0;
		end else if (restart) begin
			wr_ptr_q <= '0;
		end else if (wr_en) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end
	always_ff @(posedge clock_in) begin
		if (wr_en) begin
			buf_q[wr_ptr_q] <= wr_word;
		end
	end

	// Sticky events; set wins over the read clear
	logic [2:0] irq_set;
	logic stat_rd;
	assign irq_set[IRQ_TRIG] = first_trig;
	assign irq_set[IRQ_STOPPED] = (state_q != CAP_DONE) && (
		(state_q == CAP_RUN && pend_rec_q && ctrl_q[CTRL_STOP_ON_TRIG] && post_target == '0)
		|| (state_q == CAP_POST && wr_en && post_cnt_q + 1'b1 >= post_target));
	assign irq_set[IRQ_WRAP] = wr_en && (wr_ptr_q == {BUF_AW{1'b1}});
	assign stat_rd = dp_rd_q && hit(dp_addr_q, OFF_IRQ_STAT);
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= (stat_rd ? 3'h0 : irq_stat_q) | irq_set;
		end
	end

	// Read mux, registered at the address phase edge
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_any) begin
			hrdata_q <= 32'h0000_0000;
			if (hit(ahb_in.haddr[7:0], OFF_CTRL)) hrdata_q <= ctrl_q;
			if (hit(ahb_in.haddr[7:0], OFF_STATUS)) hrdata_q <= {27'h0, pend_rec_q, trig_seen_q,
				state_q == CAP_DONE, capturing_out, on_q};
			if (hit(ahb_in.haddr[7:0], OFF_IRQ_STAT)) hrdata_q <= {29'h0, irq_stat_q};
			if (hit(ahb_in.haddr[7:0], OFF_IRQ_MASK)) hrdata_q <= {29'h0, irq_mask_q};
			if (hit(ahb_in.haddr[7:0], OFF_RD_PTR)) hrdata_q <= {28'h0, rd_ptr_q};
			if (hit(ahb_in.haddr[7:0], OFF_RD_DATA)) hrdata_q <= buf_q[rd_ptr_q][31:0];
			if (hit(ahb_in.haddr[7:0], OFF_WR_PTR)) hrdata_q <= {28'h0, wr_ptr_q};
		end
	end

	// Status outputs
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			capturing_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			capturing_out <= range_pass && ss_pass && (state_q != CAP_DONE);
			irq_out <= |((stat_rd ? 3'h0 : irq_stat_q) & irq_mask_q | irq_set & irq_mask_q);
		end
	end

	// Assertions
	a_trig_once: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		trig_seen_q && !pend_rec_q && !restart |=> !pend_rec_q)
		else $error("second trigger record");
	a_stop_wins: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(|stop_hit) && !restart |=> !on_q)
		else $error("stop point did not clear capture");
	a_start_sets: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(|start_hit) && !(|stop_hit) && !(dp_wr_q && hit(dp_addr_q, OFF_CTRL)) |=> on_q)
		else $error("start point did not set capture");
	a_done_nowrite: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		state_q == CAP_DONE |-> !wr_en)
		else $error("write after capture stopped");
	a_no_range: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		range_en == '0 && start_en == '0 && beat_in.valid && !pend_rec_q
		&& state_q != CAP_DONE |-> wr_en)
		else $error("beat dropped with no range");
	a_zero_fill: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		state_q == CAP_RUN && pend_rec_q && ctrl_q[CTRL_STOP_ON_TRIG] && post_target == '0
		&& !restart |=> state_q == CAP_DONE)
		else $error("zero fill did not stop");
	a_post_bound: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		state_q == CAP_POST |-> post_cnt_q < post_target)
		else $error("post fill overran");
	a_wrap_ptr: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_en && !restart |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1)
		else $error("write pointer did not advance");
	a_point_acts: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(|trig_hit) && !trig_seen_q && state_q == CAP_RUN && !restart
		|=> trig_seen_q && pend_rec_q)
		else $error("trigger point not acted on");

endmodule
`default_nettype wire

// File: verif/trace_source_model.sv
// Partner model: trace source that streams beats and pulses the trigger
`timescale 1ns/1ps
`default_nettype none
module trace_source_model (
	// Clock
	input wire logic clock_in,
	// Trace stream towards the block
	output var trace_capture_pkg::trace_beat_t beat_out,
	output logic trigger_out
);
	import trace_capture_pkg::*;

	logic valid_q = 1'b0;
	logic [31:0] addr_q = 32'h0;
	logic [31:0] data_q = 32'h0;
	logic [31:0] junk_q = 32'h0;

	logic trig_q = 1'b0;

	// One driver for the trigger line
	assign trigger_out = trig_q;

	// Released lines show changing junk, so stale data never looks valid
	always @(posedge clock_in) junk_q <= junk_q + 32'h9e37;
	assign beat_out = valid_q ? {1'b1, addr_q, data_q} : {1'b0, ~junk_q, junk_q};

	// Stream n beats back to back; the source never waits on the block
	task automatic run(input logic [31:0] a, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock_in);
			valid_q <= 1'b1;
			addr_q <= a + 32'(4 * i);
			data_q <= 32'h1000 + 32'(i);
		end
		@(posedge clock_in);
		valid_q <= 1'b0;
	endtask

	// One-cycle platform trigger pulse
	task automatic pulse();
		@(posedge clock_in);
		trig_q <= 1'b1;
		@(posedge clock_in);
		trig_q <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verif/tb_trace_capture.sv
// Testbench: bus tasks, one task per scenario, verdict
`timescale 1ns/1ps
`default_nettype none
module tb_trace_capture;
	import trace_capture_pkg::*;

	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic act_q = 1'b0;
	logic wr_q = 1'b0;
	logic [31:0] addr_q = 32'h0;
	logic [31:0] hwdata_q = 32'h0;
	logic [31:0] hrdata;
	logic hrdy, hresp, cap, irq, trig;
	trace_beat_t beat;
	ahb_req_t ahb;
	int n_errors = 0;
	int n_tests = 0;

	// 250 MHz clock
	always #2 clock_in = ~clock_in;
	// Bus hready is the only slave's hreadyout
	assign ahb = '{act_q, addr_q, {act_q, 1'b0}, wr_q, 3'h2, hrdy};

	trace_capture uut (.clock_in(clock_in), .arst_n_in(arst_n_in), .beat_in(beat),
		.ext_trigger_in(trig), .ahb_in(ahb), .hwdata_in(hwdata_q), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(hresp), .capturing_out(cap), .irq_out(irq));
	trace_source_model src (.clock_in(clock_in), .beat_out(beat), .trigger_out(trig));

	task automatic results();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single word transfer; waits on hready, data taken at the closing edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock_in);
		act_q <= 1'b1;
		wr_q <= w;
		addr_q <= {24'h0, a};
		do @(posedge clock_in); while (hrdy !== 1'b1);
		act_q <= 1'b0;
		hwdata_q <= wd;
		do @(posedge clock_in); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(v, e);
	endtask

	task automatic ptr(output logic [3:0] p);
		logic [31:0] v;
		bus(1'b0, OFF_WR_PTR, 32'h0, v);
		p = v[3:0];
	endtask

	// Restart clears the write pointer and trigger history, then apply the setup
	task automatic setup(input logic [31:0] cfg);
		logic [31:0] v;
		wr(OFF_CTRL, 32'h1 << CTRL_RESTART);
		wr(OFF_CTRL, cfg);
		bus(1'b0, OFF_IRQ_STAT, 32'h0, v);
	endtask

	task automatic t_reset();
		rc(OFF_CTRL, CTRL_RESET);
		rc(OFF_IRQ_STAT, 32'h0);
		rc(OFF_IRQ_MASK, 32'h0);
		wr(8'h80, 32'hffff_ffff);
		rc(8'h80, 32'h0);
		check({31'h0, hresp}, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_wrap();
		logic [3:0] p0, p1;
		logic [31:0] v;
		setup(32'h0);
		wr(OFF_IRQ_MASK, 32'h1 << IRQ_WRAP);
		ptr(p0);
		check({31'h0, cap}, 32'h1);
		src.run(32'h100, 20);
		ptr(p1);
		check({28'h0, p1}, {28'h0, p0 + 4'h4});
		wr(OFF_RD_PTR, {28'h0, p0});
		rc(OFF_RD_DATA, 32'h1010);
		rc(OFF_RD_DATA, 32'h1011);
		check({31'h0, irq}, 32'h1);
		bus(1'b0, OFF_IRQ_STAT, 32'h0, v);
		check({31'h0, v[IRQ_WRAP]}, 32'h1);
		repeat (2) @(posedge clock_in);
		check({31'h0, irq}, 32'h0);
		$display("test wrap done");
	endtask

	task automatic t_range();
		logic [3:0] p0, p1;
		setup(32'h3 << CTRL_RANGE_EN);
		wr(OFF_RANGE_BASE, 32'h2000);
		wr(OFF_RANGE_BASE + 8'h4, 32'h200c);
		wr(OFF_RANGE_BASE + 8'h8, 32'h2100);
		wr(OFF_RANGE_BASE + 8'hc, 32'h2100);
		ptr(p0);
		src.run(32'h1ff8, 8);
		src.run(32'h20f8, 4);
		ptr(p1);
		check({28'h0, p1 - p0}, 32'h5);
		$display("test range done");
	endtask

	task automatic t_points();
		logic [3:0] p0, p1;
		setup((32'h1 << CTRL_START_EN) | (32'h2 << CTRL_STOP_EN));
		wr(OFF_POINT_BASE, 32'h3000);
		wr(OFF_POINT_BASE + 8'h4, 32'h3010);
		ptr(p0);
		src.run(32'h2f00, 4);
		ptr(p1);
		check({28'h0, p1 - p0}, 32'h0);
		src.run(32'h3000, 4);
		src.run(32'h3000, 2);
		ptr(p0);
		check({28'h0, p0 - p1}, 32'h6);
		src.run(32'h3010, 1);
		ptr(p1);
		src.run(32'h2f00, 4);
		ptr(p0);
		check({28'h0, p0 - p1}, 32'h0);
		check({31'h0, cap}, 32'h0);
		$display("test points done");
	endtask

	task automatic t_trig();
		logic [3:0] p0, p1;
		logic [31:0] v;
		setup(32'h1 << CTRL_TRIG_EN);
		wr(OFF_POINT_BASE, 32'h4000);
		wr(OFF_IRQ_MASK, 32'h1 << IRQ_TRIG);
		ptr(p0);
		// Point hit arms the record; later point and line hits add none
		src.run(32'h4000, 1);
		src.pulse();
		src.run(32'h4000, 2);
		ptr(p1);
		check({28'h0, p1 - p0}, 32'h4);
		check({31'h0, irq}, 32'h1);
		wr(OFF_RD_PTR, {28'h0, p0});
		rc(OFF_RD_DATA, 32'h1000);
		rc(OFF_RD_DATA, TRIG_RECORD[31:0]);
		rc(OFF_RD_DATA, 32'h1000);
		bus(1'b0, OFF_IRQ_STAT, 32'h0, v);
		check({31'h0, v[IRQ_TRIG]}, 32'h1);
		$display("test trigger done");
	endtask

	task automatic t_fill();
		logic [1:0] f [3] = '{FILL_0, FILL_50, FILL_99};
		int e [3] = '{1, 9, 16};
		logic [3:0] p0, p1;
		logic [31:0] v;
		for (int k = 0; k < 3; k++) begin
			setup((32'h1 << CTRL_STOP_ON_TRIG) | (32'(f[k]) << CTRL_FILL));
			ptr(p0);
			src.pulse();
			src.run(32'h500, 20);
			ptr(p1);
			check({28'h0, p1 - p0}, 32'(e[k] % 16));
			check({31'h0, cap}, 32'h0);
			// Status: trigger seen, capture done, nothing pending
			rc(OFF_STATUS, 32'hc);
			wr(OFF_RD_PTR, {28'h0, p0});
			rc(OFF_RD_DATA, TRIG_RECORD[31:0]);
			bus(1'b0, OFF_IRQ_STAT, 32'h0, v);
			check({31'h0, v[IRQ_STOPPED]}, 32'h1);
		end
		$display("test fill done");
	endtask

	// Main sequence: reset for 16 cycles, then the scenarios
	initial begin
		repeat (16) @(posedge clock_in);
		check({29'h0, hrdy, cap, irq}, 32'h4);
		arst_n_in <= 1'b1;
		t_reset();
		t_wrap();
		t_range();
		t_points();
		t_trig();
		t_fill();
		results();
	end

	// Watchdog: the scenarios need a few hundred cycles at most
	initial begin
		#80000;
		n_errors++;
		results();
	end
endmodule
`default_nettype wire
